// [logic/abc_pkg.sv]
// Shared constants, codes and register layouts of the baud clock selector
package abc_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses on the bus)
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_EXT_MODE = 4'h0;
    localparam logic [3:0] OFS_CONTROL = 4'h4;
    localparam logic [3:0] OFS_BAUD = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] EXT_MODE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'hff;

    // ----------------------------------------------------------------
    // Status register field positions
    // ----------------------------------------------------------------
    localparam int ST_AVG_BIT = 0;
    localparam int ST_EXT_BIT = 1;
    localparam int ST_PROHIB_BIT = 2;
    localparam int ST_RXBUSY_BIT = 3;
    localparam int ST_SAMPLE_BIT = 4;
    localparam int ST_MULT_LSB = 8;

    // ----------------------------------------------------------------
    // Clock source codes and basic clock multiples
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_EXTERNAL = 3'h0,
        SRC_AVG_115K_P10 = 3'h1,
        SRC_AVG_460K_P10 = 3'h2,
        SRC_AVG_720K_P32 = 3'h3,
        SRC_PROHIBITED = 3'h4,
        SRC_AVG_115K_P16 = 3'h5,
        SRC_AVG_460K_P16 = 3'h6,
        SRC_AVG_720K_P16 = 3'h7
    } abc_src_t;

    localparam int MULT_16 = 16;
    localparam int MULT_8 = 8;
    localparam int MULT_SMART = 372;

    // ----------------------------------------------------------------
    // Average rates (bit/s) and the peripheral clocks they assume (Hz)
    // ----------------------------------------------------------------
    localparam int RATE_115152 = 115152;
    localparam int RATE_460606 = 460606;
    localparam int RATE_720000 = 720000;
    localparam int RATE_115196 = 115196;
    localparam int RATE_460784 = 460784;
    localparam int PCLK_10667_HZ = 10667000;
    localparam int PCLK_16_HZ = 16000000;
    localparam int PCLK_32_HZ = 32000000;

    // ----------------------------------------------------------------
    // Register layouts and the bus request bundle
    // ----------------------------------------------------------------
    typedef struct packed {
        logic reserved7;
        logic [2:0] reservedRo;
        logic basicClockMultipleSel;
        abc_src_t clockSourceSel;
    } abc_ext_mode_t;

    typedef struct packed {
        logic [1:0] spareHi;
        logic [1:0] divExp;
        logic spareLo;
        logic smartCard;
        logic clockEnableHi;
        logic asyncMode;
    } abc_control_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } abc_wb_req_t;

endpackage

// [logic/abc_rate_accum.sv]
// Fractional pulse generator: on average num pulses every den clocks
`timescale 1ns/1ps
`default_nettype none
module abc_rate_accum #(
    parameter int ACC_W = 26
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic clear,
    input wire logic [ACC_W-1:0] num,
    input wire logic [ACC_W-1:0] den,
    output logic tick
);
    logic [ACC_W:0] acc;
    logic [ACC_W:0] next_acc;
    logic next_tick;
    logic [ACC_W:0] sum;

    always_comb begin
        sum = acc + {1'b0, num};
        next_acc = acc;
        next_tick = 1'b0;
        if (clear || !enable) begin
            next_acc = '0;
        end else if (sum >= {1'b0, den}) begin
            // Spacing varies by one clock so the mean rate is exact
            next_acc = sum - {1'b0, den};
            next_tick = 1'b1;
        end else begin
            next_acc = sum;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= '0;
            tick <= 1'b0;
        end else begin
            acc <= next_acc;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// [logic/abc_clock_select.sv]
// Basic clock source selection, rate generation and receive bit sampling
//
// Function
// - Extended mode bit 7 is reserved, always reads 0, software writes 0.
// - Extended mode bits 6 to 4 read zero and ignore writes.
// - Async basic clock select: 0 gives 16x rate, 1 gives 8x rate.
// - Source select code acts only in async mode with clock enable high.
// - Average-rate codes fix the multiple themselves, ignoring basic select.
// - Code 000 selects the external clock; code 100 is prohibited.
// - 001: 115.152 kbps 16x; 010: 460.606 kbps 8x at 10.667 MHz.
// - 011: 720 kbps average at 32 MHz with 16x basic clock.
// - 101: 115.196 kbps, 110: 460.784 kbps, both 16x at 16 MHz.
// - 111: 720 kbps average at 16 MHz with 8x basic clock.
// - Smart card, 372 clocks per bit: fastest with exponent 0, count 0.
// - Receiver latches each bit on basic pulse halfMult of the bit (the eighth at 16x, fourth at 8x), mid bit.
`timescale 1ns/1ps
`default_nettype none
module abc_clock_select
    import abc_pkg::*;
#(
    parameter int ACC_W = 26,
    parameter int FRAME_BITS = 10
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [3:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    output logic wbAck,
    input wire logic extClk,
    input wire logic rxLine,
    output logic basicTick,
    output logic [8:0] multiple,
    output logic avgActive,
    output logic sampleStrobe,
    output logic sampleBit
);
    import abc_pkg::*;

    // ----------------------------------------------------------------
    // Bus slave and registers
    // ----------------------------------------------------------------
    abc_wb_req_t req;
    abc_ext_mode_t extMode;
    abc_ext_mode_t next_extMode;
    abc_control_t ctrl;
    abc_control_t next_ctrl;
    logic [7:0] baudCount;
    logic [7:0] next_baudCount;
    logic next_wbAck;
    logic [31:0] next_wbDatOut;
    logic [31:0] statusWord;
    logic prohibited;
    logic useExt;
    logic rxBusy;

    assign req = '{cyc: wbCyc, stb: wbStb, we: wbWe, adr: wbAdr,
                   sel: wbSel, dat: wbDatIn};

    always_comb begin
        statusWord = '0;
        statusWord[ST_AVG_BIT] = avgActive;
        statusWord[ST_EXT_BIT] = useExt;
        statusWord[ST_PROHIB_BIT] = prohibited;
        statusWord[ST_RXBUSY_BIT] = rxBusy;
        statusWord[ST_SAMPLE_BIT] = sampleBit;
        statusWord[ST_MULT_LSB +: 9] = multiple;
    end

    always_comb begin
        next_extMode = extMode;
        next_ctrl = ctrl;
        next_baudCount = baudCount;
        // Ack follows a request by one cycle and drops right after
        next_wbAck = req.cyc && req.stb && !wbAck;
        next_wbDatOut = '0;
        if (req.cyc && req.stb && !wbAck) begin
            case (req.adr)
                OFS_EXT_MODE: begin
                    next_wbDatOut = {24'h000000, 4'h0,
                                     extMode.basicClockMultipleSel,
                                     extMode.clockSourceSel};
                end
                OFS_CONTROL: next_wbDatOut = {24'h000000, ctrl};
                OFS_BAUD: next_wbDatOut = {24'h000000, baudCount};
                OFS_STATUS: next_wbDatOut = statusWord;
                default: next_wbDatOut = '0;
            endcase
        end
        // A write lands on the edge where the master sees ack
        if (req.cyc && req.stb && wbAck && req.we && req.sel[0]) begin
            case (req.adr)
                OFS_EXT_MODE: begin
                    next_extMode.reserved7 = 1'b0;
                    next_extMode.reservedRo = 3'h0;
                    next_extMode.basicClockMultipleSel = req.dat[3];
                    next_extMode.clockSourceSel = abc_src_t'(req.dat[2:0]);
                end
                OFS_CONTROL: next_ctrl = abc_control_t'(req.dat[7:0]);
                OFS_BAUD: next_baudCount = req.dat[7:0];
                default: next_baudCount = baudCount;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            extMode <= abc_ext_mode_t'(EXT_MODE_RESET);
            ctrl <= abc_control_t'(CONTROL_RESET);
            baudCount <= BAUD_RESET;
            wbAck <= 1'b0;
            wbDatOut <= '0;
        end else begin
            extMode <= next_extMode;
            ctrl <= next_ctrl;
            baudCount <= next_baudCount;
            wbAck <= next_wbAck;
            wbDatOut <= next_wbDatOut;
        end
    end

    // ----------------------------------------------------------------
    // Source selection and basic clock generation
    // ----------------------------------------------------------------
    logic srcActive;
    logic avgSel;
    logic [ACC_W-1:0] num;
    logic [ACC_W-1:0] den;
    logic [8:0] selMult;
    logic [ACC_W-1:0] internalPeriod;
    logic [2:0] shiftAmt;
    logic accTick;
    logic accClear;
    logic [15:0] selKey;
    logic [15:0] next_selKey;
    logic extPrev;
    logic next_extPrev;
    logic next_basicTick;
    logic [8:0] next_multiple;
    logic next_avgActive;

    // Code only counts in async mode with clock enable high
    assign srcActive = ctrl.asyncMode && ctrl.clockEnableHi
                       && !ctrl.smartCard;
    assign prohibited = srcActive
                        && extMode.clockSourceSel == SRC_PROHIBITED;
    assign useExt = !ctrl.smartCard && ctrl.clockEnableHi
                    && (!ctrl.asyncMode
                        || extMode.clockSourceSel == SRC_EXTERNAL);
    assign avgSel = srcActive && !prohibited && !useExt;
    assign shiftAmt = {ctrl.divExp, 1'b1};

    // Tick period of the on-chip divider is (count + 1) * 2^(2n+1) clocks
    assign internalPeriod = (ACC_W'(baudCount) + ACC_W'(1)) << shiftAmt;

    always_comb begin
        num = ACC_W'(1);
        den = internalPeriod;
        // Basic select only matters while no average code is active
        selMult = extMode.basicClockMultipleSel ? 9'(MULT_8)
                                                : 9'(MULT_16);
        if (ctrl.smartCard) begin
            // Count 0, exponent 0 gives two clocks per pulse, the fastest
            selMult = 9'(MULT_SMART);
        end else if (avgSel) begin
            // Each pair is pulses per clock assuming the matching clock
            case (extMode.clockSourceSel)
                SRC_AVG_115K_P10: begin
                    num = ACC_W'(MULT_16 * RATE_115152);
                    den = ACC_W'(PCLK_10667_HZ);
                    selMult = 9'(MULT_16);
                end
                SRC_AVG_460K_P10: begin
                    num = ACC_W'(MULT_8 * RATE_460606);
                    den = ACC_W'(PCLK_10667_HZ);
                    selMult = 9'(MULT_8);
                end
                SRC_AVG_720K_P32: begin
                    num = ACC_W'(MULT_16 * RATE_720000);
                    den = ACC_W'(PCLK_32_HZ);
                    selMult = 9'(MULT_16);
                end
                SRC_AVG_115K_P16: begin
                    num = ACC_W'(MULT_16 * RATE_115196);
                    den = ACC_W'(PCLK_16_HZ);
                    selMult = 9'(MULT_16);
                end
                SRC_AVG_460K_P16: begin
                    num = ACC_W'(MULT_16 * RATE_460784);
                    den = ACC_W'(PCLK_16_HZ);
                    selMult = 9'(MULT_16);
                end
                SRC_AVG_720K_P16: begin
                    num = ACC_W'(MULT_8 * RATE_720000);
                    den = ACC_W'(PCLK_16_HZ);
                    selMult = 9'(MULT_8);
                end
                default: begin
                    num = ACC_W'(1);
                    den = internalPeriod;
                end
            endcase
        end
    end

    // Restart the accumulator whenever the selection changes, so a stale
    // remainder cannot burst pulses against a smaller divisor
    assign next_selKey = {ctrl.smartCard, ctrl.asyncMode, ctrl.clockEnableHi,
                          ctrl.divExp, baudCount, extMode.clockSourceSel};
    assign accClear = next_selKey != selKey;

    // The mean of unevenly spaced pulses matches the selected rate
    abc_rate_accum #(
        .ACC_W(ACC_W)
    ) rateGen (
        .clk(clk),
        .rst_b(rst_b),
        .enable(!useExt && !prohibited),
        .clear(accClear),
        .num(num),
        .den(den),
        .tick(accTick)
    );

    always_comb begin
        next_extPrev = extClk;
        next_multiple = selMult;
        next_avgActive = avgSel;
        if (prohibited) begin
            next_basicTick = 1'b0;
        end else if (useExt) begin
            next_basicTick = extClk && !extPrev;
        end else begin
            next_basicTick = accTick;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            selKey <= '0;
            extPrev <= 1'b0;
            basicTick <= 1'b0;
            multiple <= 9'(MULT_16);
            avgActive <= 1'b0;
        end else begin
            selKey <= next_selKey;
            extPrev <= next_extPrev;
            basicTick <= next_basicTick;
            multiple <= next_multiple;
            avgActive <= next_avgActive;
        end
    end

    // ----------------------------------------------------------------
    // Receive sampling at mid bit
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} abc_rx_state_t;

    abc_rx_state_t rxState;
    abc_rx_state_t next_rxState;
    logic [8:0] tickCnt;
    logic [8:0] next_tickCnt;
    logic [3:0] bitCnt;
    logic [3:0] next_bitCnt;
    logic next_sampleStrobe;
    logic next_sampleBit;
    logic [8:0] halfMult;

    assign halfMult = multiple >> 1;
    assign rxBusy = rxState != RX_IDLE;

    always_comb begin
        next_rxState = rxState;
        next_tickCnt = tickCnt;
        next_bitCnt = bitCnt;
        next_sampleStrobe = 1'b0;
        next_sampleBit = sampleBit;
        case (rxState)
            RX_IDLE: begin
                if (basicTick && !rxLine) begin
                    next_rxState = RX_START;
                    next_tickCnt = '0;
                    next_bitCnt = '0;
                end
            end
            RX_START: begin
                if (basicTick) begin
                    next_tickCnt = tickCnt + 9'h001;
                    // Pulse number halfMult after the edge lands mid start bit
                    if (tickCnt + 9'h001 == halfMult) begin
                        next_sampleStrobe = 1'b1;
                        next_sampleBit = rxLine;
                        next_tickCnt = '0;
                        next_bitCnt = 4'h1;
                        // A start bit gone high again was only a glitch
                        next_rxState = rxLine ? RX_IDLE : RX_BITS;
                    end
                end
            end
            RX_BITS: begin
                if (basicTick) begin
                    next_tickCnt = tickCnt + 9'h001;
                    if (tickCnt + 9'h001 == multiple) begin
                        next_sampleStrobe = 1'b1;
                        next_sampleBit = rxLine;
                        next_tickCnt = '0;
                        next_bitCnt = bitCnt + 4'h1;
                        if (bitCnt + 4'h1 == 4'(FRAME_BITS)) begin
                            next_rxState = RX_IDLE;
                        end
                    end
                end
            end
            default: next_rxState = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxState <= RX_IDLE;
            tickCnt <= '0;
            bitCnt <= '0;
            sampleStrobe <= 1'b0;
            sampleBit <= 1'b1;
        end else begin
            rxState <= next_rxState;
            tickCnt <= next_tickCnt;
            bitCnt <= next_bitCnt;
            sampleStrobe <= next_sampleStrobe;
            sampleBit <= next_sampleBit;
        end
    end
endmodule
`default_nettype wire

// [verification/abc_clock_select_assertions.sv]
// Port-level checker for the baud clock selector
`timescale 1ns/1ps
`default_nettype none
module abc_clock_select_assertions
    import abc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [3:0] wbAdr,
    input wire logic [31:0] wbDatOut,
    input wire logic wbAck,
    input wire logic basicTick,
    input wire logic [8:0] multiple,
    input wire logic avgActive,
    input wire logic sampleStrobe
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_ACK_NEXT: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("request not acknowledged in the next cycle");
    AST_ACK_PULSE: assert property (wbAck |=> !wbAck)
        else $error("acknowledge longer than one cycle");
    AST_DAT_IDLE: assert property (!wbAck |-> wbDatOut == 32'h0)
        else $error("read data not zero outside acknowledge");
    AST_EXT_RESERVED: assert property (
        wbAck && !$past(wbWe) && $past(wbAdr) == OFS_EXT_MODE
        |-> wbDatOut[7:4] == 4'h0)
        else $error("reserved mode bits read nonzero");
    AST_UPPER_ZERO: assert property (
        wbAck && $past(wbAdr) != OFS_STATUS |-> wbDatOut[31:8] == 24'h0)
        else $error("upper read bits nonzero");
    AST_MULT_LEGAL: assert property (
        multiple == 9'd16 || multiple == 9'd8 || multiple == 9'd372)
        else $error("illegal basic clock multiple");
    AST_AVG_MULT: assert property (
        avgActive |-> multiple == 9'd16 || multiple == 9'd8)
        else $error("average rate with a wrong multiple");
    AST_TICK_GAP: assert property (basicTick |=> !basicTick)
        else $error("basic clock pulses back to back");
    AST_STROBE_TICK: assert property (
        sampleStrobe |-> $past(basicTick))
        else $error("sample strobe not one cycle after a basic pulse");
    // Covers for the main scenarios
    cover property (wbAck && $past(wbWe));
    cover property (avgActive && basicTick);
    cover property (sampleStrobe);
endmodule
bind abc_clock_select
    abc_clock_select_assertions abc_clock_select_assertions_inst (
    .clk(clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .basicTick(basicTick), .multiple(multiple), .avgActive(avgActive),
    .sampleStrobe(sampleStrobe));
`default_nettype wire

// [verification/abc_line_model.sv]
// Remote transmitter model: sends one frame of start, 8 data, stop
`timescale 1ns/1ps
`default_nettype none
module abc_line_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] data,
    input wire logic [15:0] bitClocks,
    output logic line
);
    logic [9:0] shiftReg = 10'h3ff;
    int bits = 0;
    int cnt = 0;
    // Bit length follows bitClocks on every clock, not latched per frame, so both fast and slow peers are modelled
    always @(posedge clk) begin
        if (go && bits == 0) begin
            shiftReg <= {1'b1, data, 1'b0};
            bits <= 10;
            cnt <= 0;
        end else if (bits != 0) begin
            if (cnt == int'(bitClocks) - 1) begin
                cnt <= 0;
                bits <= bits - 1;
                shiftReg <= {1'b1, shiftReg[9:1]};
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
    // Idle line rests at mark level
    assign line = (bits != 0) ? shiftReg[0] : 1'b1;
endmodule
`default_nettype wire

// [verification/tb_abc_clock_select.sv]
// Self-checking bench for the baud clock selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_abc_clock_select;
    import abc_pkg::*;
    logic clk = 0, rst_b = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
    logic extClk = 0, go = 0, extRun = 0;
    logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
    logic [31:0] wbDatIn = 32'h0, wbDatOut, q;
    logic wbAck, basicTick, avgActive, sampleStrobe, sampleBit, rxLine;
    logic [8:0] multiple;
    logic [7:0] txByte = 8'h00, d;
    logic [9:0] fr;
    logic [15:0] bitClocks = 16'h0020;
    logic [2:0] extPh = 3'h0;
    int failures = 0, checkCount = 0, cycles = 0, tickCnt = 0, extCnt = 0;
    int t0, e0, n, i, c;
    always #10 clk = ~clk;
    abc_clock_select abc_clock_select_inst (.clk(clk), .rst_b(rst_b),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
        .wbAck(wbAck), .extClk(extClk), .rxLine(rxLine),
        .basicTick(basicTick), .multiple(multiple), .avgActive(avgActive),
        .sampleStrobe(sampleStrobe), .sampleBit(sampleBit));
    abc_line_model abc_line_model_inst (.clk(clk), .go(go), .data(txByte),
        .bitClocks(bitClocks), .line(rxLine));
    // ------------------------------------------------------------
    // Counters, external clock and timeout
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        extPh <= extPh + 3'h1;
        if (basicTick === 1'b1) tickCnt <= tickCnt + 1;
        if (extRun && &extPh) begin
            extClk <= ~extClk;
            if (!extClk) extCnt <= extCnt + 1;
        end
        if (cycles == 40000) begin
            failures++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d failures %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Classic cycle: hold until ack is sampled, then drop for a cycle
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [3:0] s, input logic [7:0] v);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbSel <= s;
        wbDatIn <= {24'h0, v};
        // Only the bench timeout ends a wait for the answer
        do begin
            @(posedge clk);
        end while (wbAck !== 1'b1);
        q = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask
    function automatic int expMult(input int k);
        return (k == 2 || k == 7) ? MULT_8 : MULT_16;
    endfunction
    // Average codes run against this 50 MHz clock, so the rate scales
    function automatic longint expTicks(input int k, input longint w);
        longint r, p;
        r = (k == 1) ? RATE_115152 : (k == 2) ? RATE_460606 :
            (k == 5) ? RATE_115196 : (k == 6) ? RATE_460784 : RATE_720000;
        p = (k < 3) ? PCLK_10667_HZ : (k == 3) ? PCLK_32_HZ : PCLK_16_HZ;
        return w * expMult(k) * r / p;
    endfunction
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hede568d5));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        `CHK(multiple, 9'd16)
        bus(0, OFS_EXT_MODE, 4'h1, 8'h0);
        `CHK(q, 32'h0)
        bus(0, OFS_CONTROL, 4'h1, 8'h0);
        `CHK(q, 32'h0)
        bus(0, OFS_BAUD, 4'h1, 8'h0);
        `CHK(q, 32'hff)
        bus(0, 4'h2, 4'h1, 8'h0);
        `CHK(q, 32'h0)
        for (i = 0; i < 8; i++) begin
            d = 8'($urandom);
            bus(1, OFS_EXT_MODE, 4'h1, d);
            bus(0, OFS_EXT_MODE, 4'h1, 8'h0);
            `CHK(q, {28'h0, d[3:0]})
        end
        bus(1, OFS_EXT_MODE, 4'h0, ~d);
        bus(0, OFS_EXT_MODE, 4'h1, 8'h0);
        `CHK(q, {28'h0, d[3:0]})
        bus(1, OFS_CONTROL, 4'h1, 8'h01);
        for (i = 0; i < 2; i++) begin
            bus(1, OFS_EXT_MODE, 4'h1, {4'h0, i[0], 3'h1});
            // Outputs follow the register one edge after the write
            @(posedge clk);
            `CHK(multiple, (i == 1) ? 9'd8 : 9'd16)
            `CHK(avgActive, 1'b0)
        end
        bus(1, OFS_CONTROL, 4'h1, 8'h03);
        for (c = 0; c < 8; c++) begin
            bus(1, OFS_EXT_MODE, 4'h1, {5'h01, c[2:0]});
            extRun <= (c == 0);
            repeat (4) @(posedge clk);
            t0 = tickCnt;
            e0 = extCnt;
            repeat (3000) @(posedge clk);
            if (c == 0) begin
                n = tickCnt - t0 - extCnt + e0;
                `CHK(n inside {[-1:1]}, 1'b1)
            end else if (c == 4) begin
                `CHK(tickCnt - t0, 0)
                `CHK(avgActive, 1'b0)
                bus(0, OFS_STATUS, 4'h1, 8'h0);
                `CHK(q[ST_PROHIB_BIT], 1'b1)
            end else begin
                n = tickCnt - t0 - int'(expTicks(c, 3000));
                `CHK(avgActive, 1'b1)
                `CHK(multiple, 9'(expMult(c)))
                `CHK(n inside {[-2:2]}, 1'b1)
            end
        end
        extRun <= 1'b0;
        bus(1, OFS_BAUD, 4'h1, 8'h00);
        bus(1, OFS_CONTROL, 4'h1, 8'h04);
        @(posedge clk);
        `CHK(multiple, 9'd372)
        t0 = tickCnt;
        repeat (100) @(posedge clk);
        `CHK((tickCnt - t0) inside {[49:50]}, 1'b1)
        // Exponent 1 stretches the on-chip divider to eight clocks
        bus(1, OFS_CONTROL, 4'h1, 8'h14);
        @(posedge clk);
        t0 = tickCnt;
        repeat (200) @(posedge clk);
        `CHK((tickCnt - t0) inside {[24:25]}, 1'b1)
        bus(1, OFS_CONTROL, 4'h1, 8'h01);
        for (i = 0; i < 2; i++) begin
            bus(1, OFS_EXT_MODE, 4'h1, {4'h0, i[0], 3'h0});
            bitClocks <= (i == 1) ? 16'd16 : 16'd32;
            txByte <= 8'($urandom);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            fr = {1'b1, txByte, 1'b0};
            for (c = 0; c < 10; c++) begin
                n = 0;
                do begin
                    @(posedge clk);
                    n++;
                end while (sampleStrobe !== 1'b1 && n < 400);
                `CHK(sampleBit, fr[c])
            end
            repeat (100) @(posedge clk);
        end
        summarize();
    end
endmodule
`default_nettype wire
